//--- core/tof_host_end.sv
`timescale 1ns/1ps

// Receive FIFO between serial read-out and the user side
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // Pointer advance with wrap at the depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (do_rd) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end
endmodule : rx_fifo

module tof_host_end
  import tof_pkg::*;
#(
  parameter int FRAME_BYTES = 8,
  parameter int FIFO_DEPTH = 32,
  parameter int FRAME_PERIOD_CYC = 40000
) (
  input wire logic clk,
  input wire logic rst_n,
  tof_link_if.host link,
  input wire logic frame_start,
  input wire logic timer_en,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic readout_done_irq,
  output logic frame_busy,
  input wire logic gpio_mode,
  input wire logic gpio_sclk,
  input wire logic gpio_mosi,
  input wire logic gpio_cs_n,
  output logic gpio_miso,
  output logic [31:0] safety_us
);

  host_state_e state_r;
  xfer_kind_e kind_r;
  xfer_kind_e next_kind;
  logic sclk_r;
  logic mosi_r;
  logic cs_n_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [2:0] bit_cnt_r;
  logic [15:0] byte_idx_r;
  logic [3:0] half_cnt_r;
  logic waiting_r;
  logic push_r;
  logic rdi_r;
  logic busy_r;
  logic miso_q_r;
  logic [7:0] cfg_r;
  logic cfg_pend_r;
  logic start_pend_r;
  logic [31:0] period_cnt_r;
  logic tick_r;
  logic [5:0] us_div_r;
  logic [31:0] safety_r;
  logic half_done;
  logic launch;
  logic fifo_in_ready;

  // Number of the last byte of a transfer of the given kind
  function automatic logic [15:0] last_idx(input xfer_kind_e k);
    last_idx = (k == K_READ) ? 16'(FRAME_BYTES) : 16'd1;
  endfunction : last_idx

  // Operation code of a transfer kind
  function automatic logic [7:0] op_of(input xfer_kind_e k);
    case (k)
      K_CFG: op_of = OP_CFG;
      K_START: op_of = OP_START;
      default: op_of = OP_READ;
    endcase
  endfunction : op_of

  assign half_done = (half_cnt_r == SCLK_HALF_CYC - 4'd1);
  assign launch = !gpio_mode && start_pend_r && !waiting_r;
  assign next_kind = cfg_pend_r ? K_CFG : K_START;

  // Periodic frame timer, free of the read-out state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (!timer_en || period_cnt_r == 32'(FRAME_PERIOD_CYC - 1)) begin
        period_cnt_r <= 32'h0;
        tick_r <= timer_en;
      end else begin
        period_cnt_r <= period_cnt_r + 32'h1;
      end
    end
  end

  // Independent microsecond counter for laser exposure bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      us_div_r <= 6'h00;
      safety_r <= 32'h0;
    end else if (us_div_r == US_CYC - 6'd1) begin
      us_div_r <= 6'h00;
      safety_r <= safety_r + 32'h1;
    end else begin
      us_div_r <= us_div_r + 6'd1;
    end
  end

  // Pending configuration and start; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
      cfg_pend_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else begin
      if (cfg_valid) begin
        cfg_r <= cfg_data;
        cfg_pend_r <= 1'b1;
      end else if (state_r == H_IDLE && launch && cfg_pend_r) begin
        cfg_pend_r <= 1'b0;
      end
      if (frame_start || tick_r) begin
        start_pend_r <= 1'b1;
      end else if (state_r == H_IDLE && launch) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  // Serial transfer engine: mode 3, one byte at a time, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= H_IDLE;
      kind_r <= K_CFG;
      sclk_r <= PIN_IDLE;
      mosi_r <= PIN_IDLE;
      cs_n_r <= PIN_IDLE;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      bit_cnt_r <= 3'd0;
      byte_idx_r <= 16'h0;
      half_cnt_r <= 4'h0;
      waiting_r <= 1'b0;
      push_r <= 1'b0;
      rdi_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      rdi_r <= 1'b0;
      half_cnt_r <= half_done ? 4'h0 : half_cnt_r + 4'h1;
      case (state_r)
        H_IDLE: begin
          half_cnt_r <= 4'h0;
          byte_idx_r <= 16'h0;
          bit_cnt_r <= 3'd0;
          if (gpio_mode) begin
            sclk_r <= gpio_sclk;
            mosi_r <= gpio_mosi;
            cs_n_r <= gpio_cs_n;
          end else begin
            sclk_r <= PIN_IDLE;
            mosi_r <= PIN_IDLE;
            cs_n_r <= PIN_IDLE;
            if (launch) begin
              kind_r <= next_kind;
              tx_sh_r <= op_of(next_kind);
              state_r <= H_SETUP;
            end else if (waiting_r && link.measurement_done_irq) begin
              kind_r <= K_READ;
              tx_sh_r <= OP_READ;
              state_r <= H_SETUP;
            end
          end
        end
        H_SETUP: begin
          cs_n_r <= 1'b0;
          if (half_done) begin
            sclk_r <= 1'b0;
            mosi_r <= tx_sh_r[7];
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            rx_sh_r <= {rx_sh_r[6:0], link.miso};
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'd1;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done && bit_cnt_r != 3'd0) begin
            sclk_r <= 1'b0;
            mosi_r <= tx_sh_r[7];
            state_r <= H_LOW;
          end else if (half_done) begin
            push_r <= (kind_r == K_READ) && (byte_idx_r != 16'h0);
            if (byte_idx_r == last_idx(kind_r)) begin
              state_r <= H_END;
            end else begin
              byte_idx_r <= byte_idx_r + 16'h1;
              tx_sh_r <= (kind_r == K_CFG) ? cfg_r : FILL_BYTE;
              state_r <= H_GAP;
            end
          end
        end
        H_GAP: begin
          half_cnt_r <= 4'h0;
          if (kind_r != K_READ || (fifo_in_ready && !push_r)) begin
            sclk_r <= 1'b0;
            mosi_r <= tx_sh_r[7];
            state_r <= H_LOW;
          end
        end
        H_END: begin
          mosi_r <= PIN_IDLE;
          if (half_done) begin
            cs_n_r <= 1'b1;
            case (kind_r)
              K_CFG: begin
                kind_r <= K_START;
                tx_sh_r <= OP_START;
                byte_idx_r <= 16'h0;
                state_r <= H_SETUP;
              end
              K_START: begin
                waiting_r <= 1'b1;
                state_r <= H_IDLE;
              end
              default: begin
                waiting_r <= 1'b0;
                rdi_r <= 1'b1;
                state_r <= H_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // Status and GPIO sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      miso_q_r <= PIN_IDLE;
    end else begin
      busy_r <= waiting_r | (state_r != H_IDLE);
      miso_q_r <= link.miso;
    end
  end

  rx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(rx_sh_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
  assign link.cs_n = cs_n_r;
  assign readout_done_irq = rdi_r;
  assign frame_busy = busy_r;
  assign gpio_miso = miso_q_r;
  assign safety_us = safety_r;

endmodule : tof_host_end

//--- core/tof_pkg.sv
package tof_pkg;

  // Operation codes carried in the first (address) byte of an SPI transfer
  localparam logic [7:0] OP_CFG = 8'h10;
  localparam logic [7:0] OP_START = 8'h20;
  localparam logic [7:0] OP_READ = 8'h30;

  // Reset values of the pins and of the configuration byte, and the fill byte sent as dummy data
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // Clock and timing figures
  localparam int CLK_NS = 25;
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_HALF_CYC_I = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_CYC_I < 1 ? 1 : SCLK_HALF_CYC_I);
  localparam int US_NS = 1000;
  localparam logic [5:0] US_CYC = 6'(US_NS / CLK_NS);

  // Host transfer engine states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_GAP = 3'b100,
    H_END = 3'b101
  } host_state_e;

  // Kinds of host transfer
  typedef enum logic [1:0] {
    K_CFG = 2'b00,
    K_START = 2'b01,
    K_READ = 2'b10
  } xfer_kind_e;

  // Sensor acquisition states
  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_ACQ = 1'b1
  } sensor_state_e;

endpackage : tof_pkg

//--- core/tof_link_if.sv
`timescale 1ns/1ps
interface tof_link_if;
  logic sclk;
  logic mosi;
  logic cs_n;
  logic miso_drv;
  logic miso_oe;
  logic miso;
  logic measurement_done_irq;

  // Shared data-out line, pulled high when the sensor does not drive it
  assign miso = miso_oe ? miso_drv : 1'b1;

  modport host (
    output sclk,
    output mosi,
    output cs_n,
    input miso,
    input measurement_done_irq
  );

  modport sensor (
    input sclk,
    input mosi,
    input cs_n,
    output miso_drv,
    output miso_oe,
    output measurement_done_irq
  );
endinterface : tof_link_if

//--- core/tof_sensor_end.sv
`timescale 1ns/1ps
module tof_sensor_end
  import tof_pkg::*;
#(
  parameter int FRAME_BYTES = 8,
  parameter logic [127:0] EE_INIT = 128'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  tof_link_if.sensor link,
  input wire logic acq_valid,
  input wire logic [7:0] acq_data,
  output logic acq_en,
  output logic [7:0] cfg_word
);

  localparam int IW = (FRAME_BYTES > 1) ? $clog2(FRAME_BYTES) : 1;

  logic sclk_q_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic first_r;
  logic [7:0] addr_r;
  logic start_req_r;
  sensor_state_e state_r;
  logic [IW-1:0] wr_idx_r;
  logic [IW-1:0] rd_idx_r;
  logic [7:0] mem_r [FRAME_BYTES];
  logic [7:0] tx_sh_r;
  logic [6:0] ee_addr_r;
  logic ee_sel_r;
  logic acq_en_r;
  logic irq_r;
  logic miso_r;
  logic miso_oe_r;

  logic cs_act;
  logic rise;
  logic fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic read_open;
  logic read_next;
  logic frame_last;

  // Edge detection on the host clock, mode 3 framing
  assign cs_act = ~link.cs_n;
  assign rise = link.sclk & ~sclk_q_r;
  assign fall = ~link.sclk & sclk_q_r;
  assign rx_byte = {rx_sh_r, link.mosi};
  assign byte_done = cs_act & rise & (bit_cnt_r == 3'd7);
  assign read_open = byte_done & first_r & (rx_byte == OP_READ);
  assign read_next = byte_done & ~first_r & (addr_r == OP_READ);
  assign frame_last = (wr_idx_r == IW'(FRAME_BYTES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= PIN_IDLE;
    end else begin
      sclk_q_r <= link.sclk;
    end
  end

  // Byte framing: address first, then data bytes, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 3'd0;
      rx_sh_r <= 7'h00;
      first_r <= 1'b1;
      addr_r <= 8'h00;
    end else if (!cs_act) begin
      bit_cnt_r <= 3'd0;
      first_r <= 1'b1;
    end else if (rise) begin
      rx_sh_r <= rx_byte[6:0];
      bit_cnt_r <= bit_cnt_r + 3'd1;
      if (bit_cnt_r == 3'd7) begin
        first_r <= 1'b0;
        if (first_r) begin
          addr_r <= rx_byte;
        end
      end
    end
  end

  // Configuration byte written by the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_word <= CFG_RESET;
    end else if (byte_done & ~first_r & (addr_r == OP_CFG)) begin
      cfg_word <= rx_byte;
    end
  end

  // Start request, held until the bus is released; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_req_r <= 1'b0;
    end else if (byte_done & ~first_r & (addr_r == OP_START)) begin
      start_req_r <= 1'b1;
    end else if (state_r == S_IDLE && !cs_act) begin
      start_req_r <= 1'b0;
    end
  end

  // Frame acquisition: runs alone after a start, halts under chip select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      wr_idx_r <= '0;
      acq_en_r <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_req_r && !cs_act) begin
            state_r <= S_ACQ;
            wr_idx_r <= '0;
            acq_en_r <= 1'b1;
          end
        end
        S_ACQ: begin
          if (cs_act) begin
            state_r <= S_IDLE;
            acq_en_r <= 1'b0;
          end else if (acq_valid) begin
            wr_idx_r <= wr_idx_r + IW'(1);
            if (frame_last) begin
              state_r <= S_IDLE;
              acq_en_r <= 1'b0;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
          acq_en_r <= 1'b0;
        end
      endcase
    end
  end

  assign acq_en = acq_en_r;

  // Frame storage
  always_ff @(posedge clk) begin
    if (state_r == S_ACQ && !cs_act && acq_valid) begin
      mem_r[wr_idx_r] <= acq_data;
    end
  end

  // Completion flag on the dedicated line; cleared when read-out begins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (state_r == S_ACQ && !cs_act && acq_valid && frame_last) begin
      irq_r <= 1'b1;
    end else if (read_open) begin
      irq_r <= 1'b0;
    end
  end

  assign link.measurement_done_irq = irq_r;

  // Read-out shift register and the bit-banged storage port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= 8'h00;
      rd_idx_r <= '0;
      ee_addr_r <= 7'h00;
      ee_sel_r <= 1'b0;
      miso_r <= PIN_IDLE;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= cs_act | ee_sel_r;
      if (cs_act) begin
        ee_sel_r <= 1'b0;
        if (read_open) begin
          tx_sh_r <= mem_r[0];
          rd_idx_r <= IW'(1);
        end else if (read_next) begin
          tx_sh_r <= (32'(rd_idx_r) < FRAME_BYTES) ? mem_r[rd_idx_r] : FILL_BYTE;
          rd_idx_r <= rd_idx_r + IW'(1);
        end else if (fall) begin
          miso_r <= tx_sh_r[7];
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
      end else if (rise) begin
        ee_sel_r <= 1'b1;
        ee_addr_r <= {ee_addr_r[5:0], link.mosi};
        miso_r <= EE_INIT[{ee_addr_r[5:0], link.mosi}];
      end
    end
  end

  assign link.miso_drv = miso_r;
  assign link.miso_oe = miso_oe_r;

endmodule : tof_sensor_end

//--- tb/tof_link_asserts.sv
`timescale 1ns/1ps
module tof_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic measurement_done_irq
);
  logic [7:0] bits_r;

  // Counts serial clock rises inside one select window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_r <= 8'h00;
    end else if (cs_n) begin
      bits_r <= 8'h00;
    end else if ($rose(sclk)) begin
      bits_r <= bits_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_cs_setup;
    $fell(cs_n) |-> sclk ##1 !cs_n;
  endproperty
  a_cs_setup: assert property (p_cs_setup)
    else $error("serial clock not idle high at select");

  property p_sclk_half;
    !cs_n && $fell(sclk) |=> !sclk ##1 sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock low phase not two cycles");

  property p_mosi_hold;
    !cs_n && $rose(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data moved on capture edge");

  property p_end_high;
    $rose(cs_n) |-> sclk && $past(sclk, 2);
  endproperty
  a_end_high: assert property (p_end_high)
    else $error("select released with clock low");

  property p_whole_bytes;
    $rose(cs_n) |-> bits_r[2:0] == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("transfer not whole bytes");

  property p_irq_idle;
    $rose(measurement_done_irq) |-> cs_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle)
    else $error("done raised inside a transfer");

  property p_irq_hold;
    measurement_done_irq && cs_n |=> measurement_done_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("done dropped without read");

  property p_irq_clear;
    $fell(measurement_done_irq) |-> !cs_n && bits_r == 8'h08;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("done cleared away from read address");
endmodule : tof_link_asserts

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tof_pkg::*;
  localparam logic [127:0] EE = 128'h0123456789ABCDEF_FEDCBA9876543210;
  logic clk = 1'h0;
  logic rst_n, frame_start, timer_en, cfg_valid, rd_ready, gpio_mode, drain;
  logic gpio_sclk, gpio_mosi, gpio_cs_n, acq_valid, acq_valid_b, acq_d;
  logic rd_valid, readout_done_irq, frame_busy, gpio_miso, acq_en, acq_en_b;
  logic [7:0] cfg_data, acq_data, rd_data, cfg_word, cfg;
  logic [6:0] addr;
  logic [31:0] safety_us;
  logic [7:0] exp_q[$];
  int fail_count = 0, checks_done = 0, frames = 0, dones = 0, cyc = 0, i, n;

  tof_link_if u_tof_link_if();
  tof_link_if u_tof_link_if_b();

  tof_host_end #(.FRAME_PERIOD_CYC(200)) u_tof_host_end (.clk(clk), .rst_n(rst_n),
    .link(u_tof_link_if.host), .frame_start(frame_start), .timer_en(timer_en),
    .cfg_valid(cfg_valid), .cfg_data(cfg_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .readout_done_irq(readout_done_irq), .frame_busy(frame_busy),
    .gpio_mode(gpio_mode), .gpio_sclk(gpio_sclk), .gpio_mosi(gpio_mosi),
    .gpio_cs_n(gpio_cs_n), .gpio_miso(gpio_miso), .safety_us(safety_us));
  tof_sensor_end #(.EE_INIT(EE)) u_tof_sensor_end (.clk(clk), .rst_n(rst_n),
    .link(u_tof_link_if.sensor), .acq_valid(acq_valid), .acq_data(acq_data),
    .acq_en(acq_en), .cfg_word(cfg_word));
  // Second sensor faces the bench, which breaks the select rule on purpose
  tof_sensor_end u_tof_sensor_end_b (.clk(clk), .rst_n(rst_n),
    .link(u_tof_link_if_b.sensor), .acq_valid(acq_valid_b), .acq_data(8'h00),
    .acq_en(acq_en_b), .cfg_word());
  tof_link_asserts u_tof_link_asserts (.clk(clk), .rst_n(rst_n),
    .sclk(u_tof_link_if.sclk), .mosi(u_tof_link_if.mosi), .cs_n(u_tof_link_if.cs_n),
    .measurement_done_irq(u_tof_link_if.measurement_done_irq));

  always #12.5 clk = ~clk;

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  task chk_data(input logic [7:0] got, input logic [7:0] exp);
    chk_val({24'h000000, got}, {24'h000000, exp});
  endtask : chk_data

  task end_sim;
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task pulse_start;
    frame_start = 1'h1;
    @(negedge clk);
    frame_start = 1'h0;
  endtask : pulse_start

  // Waits for the next read-out completion, bounded
  task wait_done;
    int k;
    int d0;
    d0 = dones;
    for (k = 0; k < 4000 && dones == d0; k++) @(negedge clk);
  endtask : wait_done

  // One byte on the bench-driven link, mode 3, most significant bit first
  task spi_b(input logic [7:0] b);
    int k;
    for (k = 7; k >= 0; k--) begin
      u_tof_link_if_b.sclk = 1'h0;
      u_tof_link_if_b.mosi = b[k];
      repeat (2) @(negedge clk);
      u_tof_link_if_b.sclk = 1'h1;
      repeat (2) @(negedge clk);
    end
  endtask : spi_b

  // Acquisition driver and read-out pacing, with expected bytes noted as taken
  always @(negedge clk) begin
    acq_valid <= acq_en && ($urandom_range(3) != 0);
    acq_data <= 8'($urandom);
    rd_ready <= drain && ($urandom_range(1) == 1);
  end
  always @(posedge clk) begin
    if (acq_en && acq_valid && u_tof_link_if.cs_n) exp_q.push_back(acq_data);
  end

  // Output monitor, event counters and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    acq_d <= acq_en;
    if (acq_en && !acq_d) frames <= frames + 1;
    if (readout_done_irq === 1'h1) dones <= dones + 1;
    if (rd_valid === 1'h1 && rd_ready) begin
      if (exp_q.size() != 0) chk_data(rd_data, exp_q.pop_front());
      else chk_val(32'h0, 32'h1);
    end
    if (cyc == 20000) begin
      fail_count++;
      end_sim;
    end
  end

  initial begin
    {rst_n, frame_start, timer_en, cfg_valid, gpio_mode, drain, acq_valid_b} = 7'h00;
    {gpio_sclk, gpio_mosi, gpio_cs_n} = 3'h7;
    {u_tof_link_if_b.sclk, u_tof_link_if_b.mosi, u_tof_link_if_b.cs_n} = 3'h7;
    {cfg_data, acq_valid, acq_data, rd_ready, acq_d} = 19'h00000;
    void'($urandom(68875));
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk_val({u_tof_link_if.sclk, u_tof_link_if.cs_n, frame_busy, acq_en}, 4'hC);
    // Configured single frame, then quiet
    drain = 1'h1;
    cfg = 8'($urandom);
    cfg_valid = 1'h1;
    cfg_data = cfg;
    @(negedge clk);
    cfg_valid = 1'h0;
    pulse_start;
    for (i = 0; i < 500 && !acq_en; i++) @(negedge clk);
    chk_val(cfg_word, cfg);
    for (i = 0; i < 500 && !u_tof_link_if.measurement_done_irq; i++) @(negedge clk);
    chk_val({acq_en, u_tof_link_if.measurement_done_irq}, 2'h1);
    wait_done;
    repeat (600) @(negedge clk);
    chk_val(frames, 1);
    chk_val(dones, 1);
    chk_val(exp_q.size(), 0);
    $display("Test single frame done");
    // Fill the buffer until read-out stalls, then drain
    drain = 1'h0;
    for (n = 0; n < 4; n++) begin
      pulse_start;
      wait_done;
    end
    pulse_start;
    repeat (600) @(negedge clk);
    chk_val({u_tof_link_if.cs_n, frame_busy, 6'(frames)}, 8'h46);
    pulse_start;
    repeat (200) @(negedge clk);
    chk_val(frames, 6);
    drain = 1'h1;
    wait_done;
    wait_done;
    repeat (300) @(negedge clk);
    chk_val({8'(frames), 8'(exp_q.size())}, 16'h0700);
    $display("Test buffer full done");
    // Periodic starts
    n = frames;
    timer_en = 1'h1;
    repeat (1500) @(negedge clk);
    timer_en = 1'h0;
    chk_val((frames - n) >= 3 && (frames - n) <= 8, 1);
    repeat (1500) @(negedge clk);
    chk_val({frame_busy, 8'(exp_q.size())}, 9'h000);
    $display("Test periodic done");
    // Pins as plain I/O and storage bit read
    gpio_mode = 1'h1;
    for (i = 0; i < 4; i++) begin
      gpio_mosi = 1'($urandom);
      repeat (2) @(negedge clk);
      chk_val(u_tof_link_if.mosi, gpio_mosi);
    end
    addr = 7'($urandom);
    gpio_cs_n = 1'h0;
    repeat (3) @(negedge clk);
    gpio_cs_n = 1'h1;
    repeat (3) @(negedge clk);
    for (i = 6; i >= 0; i--) begin
      gpio_mosi = addr[i];
      gpio_sclk = 1'h0;
      repeat (2) @(negedge clk);
      gpio_sclk = 1'h1;
      repeat (2) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    chk_val(gpio_miso, EE[addr]);
    gpio_mode = 1'h0;
    // Safety counter ticks once per microsecond, whatever the link does
    n = int'(safety_us);
    repeat (400) @(negedge clk);
    chk_val(safety_us - 32'(n), 32'(400 / US_CYC));
    $display("Test pin access done");
    // Select asserted mid-acquisition halts the second sensor
    u_tof_link_if_b.cs_n = 1'h0;
    repeat (2) @(negedge clk);
    spi_b(OP_START);
    spi_b(8'h00);
    repeat (2) @(negedge clk);
    u_tof_link_if_b.cs_n = 1'h1;
    for (i = 0; i < 20 && !acq_en_b; i++) @(negedge clk);
    chk_val(acq_en_b, 1);
    acq_valid_b = 1'h1;
    repeat (3) @(negedge clk);
    acq_valid_b = 1'h0;
    u_tof_link_if_b.cs_n = 1'h0;
    repeat (3) @(negedge clk);
    chk_val(acq_en_b, 0);
    u_tof_link_if_b.cs_n = 1'h1;
    repeat (200) @(negedge clk);
    chk_val({acq_en_b, u_tof_link_if_b.measurement_done_irq}, 2'h0);
    $display("Test abort done");
    end_sim;
  end
endmodule : tb_top
